// >>> ibp_pkg.sv
// shared constants, types and helpers for the b-channel pcm port
// assumes a 50 MHz system clock on both ends of the link
package ibp_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_NS = 20;
  localparam int LINK_PERIOD_NS = 160;
  localparam int HALF_DIV = LINK_PERIOD_NS / (2 * SYS_NS);
  localparam int FRAME_NS = 125000;
  localparam int FRAME_SYS_CYCLES = FRAME_NS / SYS_NS;

  // ****************************************
  // word and slot layout
  // ****************************************
  localparam int WORD_BITS = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [5:0] SLOT_B1_BASE = 6'h00;
  localparam logic [5:0] SLOT_B2_BASE = 6'h08;
  localparam logic [5:0] SLOT_LEN = 6'h08;
  localparam logic [7:0] IDLE_WORD = 8'hFF;

  typedef enum logic [0:0] {
    IBP_ST_IDLE = 1'b0,
    IBP_ST_RUN = 1'b1
  } ibp_state_type;

  // first bit index of the chosen b channel
  function automatic logic [5:0] slot_base(input logic chan_b2);
    slot_base = chan_b2 ? SLOT_B2_BASE : SLOT_B1_BASE;
  endfunction

  // true while a bit index lies inside the chosen slot
  function automatic logic in_slot(input logic [5:0] bit_idx, input logic chan_b2);
    in_slot = (bit_idx >= slot_base(chan_b2)) && (bit_idx < (slot_base(chan_b2) + SLOT_LEN));
  endfunction

endpackage

// >>> ibp_if.sv
// link between the pcm highway master and the codec port
// the tx line is open while the codec's enable is high; a pull-up is modelled
`timescale 1ns/10ps
`default_nettype none
interface ibp_if;
  logic bclk;
  logic sync;
  logic rxd;
  logic txd;
  logic txd_oe_n;
  logic txd_line;

  // undriven line idles high through the pull-up
  assign txd_line = txd_oe_n ? 1'b1 : txd;

  modport ctrl (
    output bclk,
    output sync,
    output rxd,
    input txd_line
  );

  modport codec (
    input bclk,
    input sync,
    input rxd,
    output txd,
    output txd_oe_n
  );
endinterface
`default_nettype wire

// >>> ibp_fifo.sv
// synchronous fifo with valid/ready on both sides
// single clock; one write and one read may happen in the same cycle
`timescale 1ns/10ps
`default_nettype none
module ibp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;

  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire push = in_valid_in && !full;
  wire pop = out_ready_in && !empty;

  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> ibp_codec_end.sv
// codec end of the b-channel pcm port, idl and gci timing
// link pins come from another domain and are synchronised before use
// Notes on behaviour
// - idl: one tx and rx word, same channel
// - master syncs every 125 us, idl
// - gci: one tx and rx word, same channel
// - master pulses frame sync every 125 us
// - idl sync sampled on clock fall
// - idl receive bits captured on clock fall
// - idl drive tx bits from clock rise
// - idl release tx on fall after word
// - gci frame sync sampled on clock fall
// - gci drive from next rise after sync
// - gci b1 sync rising while clock high drives
// - gci release at second fall of lsb
// - gci input bits captured on clock rise
`timescale 1ns/10ps
`default_nettype none
module ibp_codec_end #(
  parameter int FIFO_DEPTH = ibp_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  ibp_if.codec link,
  input wire logic mode_gci_in,
  input wire logic chan_b2_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic clk_s1_reg;
  logic clk_s2_reg;
  logic clk_d_reg;
  logic fs_s1_reg;
  logic fs_s2_reg;
  logic fs_d_reg;
  logic din_s1_reg;
  logic din_s2_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_d_reg <= 1'b0;
      fs_s1_reg <= 1'b0;
      fs_s2_reg <= 1'b0;
      fs_d_reg <= 1'b0;
      din_s1_reg <= 1'b1;
      din_s2_reg <= 1'b1;
    end
    else
    begin
      clk_s1_reg <= link.bclk;
      clk_s2_reg <= clk_s1_reg;
      clk_d_reg <= clk_s2_reg;
      fs_s1_reg <= link.sync;
      fs_s2_reg <= fs_s1_reg;
      fs_d_reg <= fs_s2_reg;
      din_s1_reg <= link.rxd;
      din_s2_reg <= din_s1_reg;
    end
  end

  wire clk_rise = clk_s2_reg && !clk_d_reg;
  wire clk_fall = !clk_s2_reg && clk_d_reg;
  wire fs_rise = fs_s2_reg && !fs_d_reg;

  // ****************************************
  // transmit buffer
  // ****************************************
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  ibp_fifo #(
    .WIDTH(ibp_pkg::WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) ibp_fifo_inst (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_data_in(tx_data_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop)
  );

  // an empty buffer sends the idle pattern rather than stalling the slot
  wire [7:0] tx_word = fifo_valid ? fifo_data : ibp_pkg::IDLE_WORD;

  // ****************************************
  // frame state
  // ****************************************
  ibp_pkg::ibp_state_type state_reg;
  ibp_pkg::ibp_state_type state_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic mode_reg;
  logic mode_next;
  logic chan_reg;
  logic chan_next;
  logic [7:0] txsh_reg;
  logic [7:0] txsh_next;
  logic [7:0] rxsh_reg;
  logic [7:0] rxsh_next;
  logic dout_reg;
  logic dout_next;
  logic oe_n_reg;
  logic oe_n_next;
  logic [7:0] rx_data_reg;
  logic [7:0] rx_data_next;
  logic rx_valid_reg;
  logic rx_valid_next;

  wire running = (state_reg == ibp_pkg::IBP_ST_RUN);
  // gci runs two data clocks per bit
  wire [5:0] bit_idx = mode_reg ? {1'b0, cnt_reg[5:1]} : cnt_reg;
  wire [5:0] base = ibp_pkg::slot_base(chan_reg);
  wire [5:0] last_bit = base + ibp_pkg::SLOT_LEN - 6'h01;
  wire [5:0] slot_end = base + ibp_pkg::SLOT_LEN;
  wire [5:0] cnt_inc = cnt_reg + 6'h01;
  wire [5:0] rel_cnt = mode_reg ? {slot_end[4:0], 1'b0} : slot_end;
  wire in_slot = ibp_pkg::in_slot(bit_idx, chan_reg);

  wire idl_start = !mode_gci_in && clk_fall && fs_s2_reg;
  wire gci_start = mode_gci_in && fs_rise;
  wire start_evt = idl_start || gci_start;
  // sync rising with the clock already high starts a b1 word at once
  wire gci_now = gci_start && clk_s2_reg && !chan_b2_in;

  wire drive_now = running && !start_evt && clk_rise && in_slot
                   && (!mode_reg || !cnt_reg[0]);
  wire first_now = drive_now && (bit_idx == base);
  wire cap_now = running && !start_evt && in_slot
                 && (mode_reg ? (clk_rise && cnt_reg[0]) : clk_fall);
  wire fall_now = running && !start_evt && clk_fall;
  // a frame sync not seen high at the first fall is a glitch
  wire gci_abort = fall_now && mode_reg && (cnt_reg == 6'h00) && !fs_s2_reg;

  assign fifo_pop = fifo_valid && (gci_now || first_now);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    mode_next = mode_reg;
    chan_next = chan_reg;
    txsh_next = txsh_reg;
    rxsh_next = rxsh_reg;
    dout_next = dout_reg;
    oe_n_next = oe_n_reg;
    rx_data_next = rx_data_reg;
    rx_valid_next = 1'b0;
    if (start_evt)
    begin
      state_next = ibp_pkg::IBP_ST_RUN;
      cnt_next = 6'h00;
      mode_next = mode_gci_in;
      chan_next = chan_b2_in;
      oe_n_next = 1'b1;
      if (gci_now)
      begin
        dout_next = tx_word[7];
        txsh_next = {tx_word[6:0], 1'b0};
        oe_n_next = 1'b0;
      end
    end
    else if (gci_abort)
    begin
      state_next = ibp_pkg::IBP_ST_IDLE;
      oe_n_next = 1'b1;
    end
    else
    begin
      if (drive_now)
      begin
        dout_next = first_now ? tx_word[7] : txsh_reg[7];
        txsh_next = first_now ? {tx_word[6:0], 1'b0} : {txsh_reg[6:0], 1'b0};
        oe_n_next = 1'b0;
      end
      if (cap_now)
      begin
        rxsh_next = {rxsh_reg[6:0], din_s2_reg};
        if (bit_idx == last_bit)
        begin
          rx_data_next = {rxsh_reg[6:0], din_s2_reg};
          rx_valid_next = 1'b1;
        end
      end
      if (fall_now)
      begin
        cnt_next = cnt_inc;
        if (cnt_inc == rel_cnt)
        begin
          oe_n_next = 1'b1;
          state_next = ibp_pkg::IBP_ST_IDLE;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= ibp_pkg::IBP_ST_IDLE;
      cnt_reg <= 6'h00;
      mode_reg <= 1'b0;
      chan_reg <= 1'b0;
      txsh_reg <= 8'h00;
      rxsh_reg <= 8'h00;
      dout_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      mode_reg <= mode_next;
      chan_reg <= chan_next;
      txsh_reg <= txsh_next;
      rxsh_reg <= rxsh_next;
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.txd = dout_reg;
  assign link.txd_oe_n = oe_n_reg;
  assign rx_data_out = rx_data_reg;
  assign rx_valid_out = rx_valid_reg;

endmodule
`default_nettype wire

// >>> ibp_ctrl_end.sv
// highway master end: makes the bit clock and frame sync, swaps one word per frame
// the codec line is sampled at the edge itself; the two-cycle request delay only matches its input synchroniser
`timescale 1ns/10ps
`default_nettype none
module ibp_ctrl_end #(
  parameter int FRAME_CYCLES = ibp_pkg::FRAME_SYS_CYCLES,
  parameter int HALF_DIV = ibp_pkg::HALF_DIV
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  ibp_if.ctrl link,
  input wire logic mode_gci_in,
  input wire logic chan_b2_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out
);
  localparam int FRAME_PERIODS = FRAME_CYCLES / (2 * HALF_DIV);

  // ****************************************
  // clock divider and frame counter
  // ****************************************
  logic [7:0] div_reg;
  logic bclk_reg;
  logic [15:0] per_reg;
  logic sync_reg;
  logic dout_reg;
  logic [7:0] txsh_reg;
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic in_s1_reg;
  logic in_s2_reg;
  logic [1:0] req_pipe_reg;
  logic [1:0] last_pipe_reg;
  logic [7:0] rxsh_reg;
  logic [7:0] rx_data_reg;
  logic rx_valid_reg;

  wire tick = (div_reg == 8'(HALF_DIV - 1));
  wire rise = tick && !bclk_reg;
  wire fall = tick && bclk_reg;
  wire [15:0] per_next = (per_reg == 16'(FRAME_PERIODS - 1)) ? 16'h0000 : per_reg + 16'h0001;

  // bit index of the period that starts at this rise, and of the current one
  wire [5:0] drv_bit = mode_gci_in ? per_next[6:1] : per_next[5:0] - 6'h01;
  wire drv_ok = (per_next < 16'h0040) && (mode_gci_in ? !per_next[0] : (per_next != 16'h0000));
  wire drive = rise && drv_ok && ibp_pkg::in_slot(drv_bit, chan_b2_in);
  wire first = drive && (drv_bit == ibp_pkg::slot_base(chan_b2_in));
  wire [5:0] cur_bit = mode_gci_in ? per_reg[6:1] : per_reg[5:0] - 6'h01;
  wire samp_ok = (per_reg < 16'h0040) && (mode_gci_in ? (rise && per_next[0]) : (fall && per_reg != 16'h0000));
  wire [5:0] samp_bit = mode_gci_in ? drv_bit : cur_bit;
  wire samp = samp_ok && ibp_pkg::in_slot(samp_bit, chan_b2_in);
  wire samp_last = samp_bit == (ibp_pkg::slot_base(chan_b2_in) + ibp_pkg::SLOT_LEN - 6'h01);
  wire [7:0] word = hold_full_reg ? hold_reg : ibp_pkg::IDLE_WORD;

  assign tx_ready_out = !hold_full_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      div_reg <= 8'h00;
      bclk_reg <= 1'b0;
      per_reg <= 16'(FRAME_PERIODS - 1);
      sync_reg <= 1'b0;
    end
    else
    begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      if (tick)
      begin
        bclk_reg <= !bclk_reg;
      end
      if (rise)
      begin
        per_reg <= per_next;
        sync_reg <= (per_next == 16'h0000);
      end
    end
  end

  // ****************************************
  // transmit toward the codec
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      dout_reg <= 1'b1;
      txsh_reg <= 8'h00;
      hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
    end
    else
    begin
      if (drive)
      begin
        dout_reg <= first ? word[7] : txsh_reg[7];
        txsh_reg <= first ? {word[6:0], 1'b0} : {txsh_reg[6:0], 1'b0};
      end
      if (tx_valid_in && !hold_full_reg)
      begin
        hold_reg <= tx_data_in;
        hold_full_reg <= 1'b1;
      end
      else if (first)
      begin
        hold_full_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // receive from the codec
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      in_s1_reg <= 1'b1;
      in_s2_reg <= 1'b1;
      req_pipe_reg <= 2'b00;
      last_pipe_reg <= 2'b00;
      rxsh_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end
    else
    begin
      in_s1_reg <= link.txd_line;
      in_s2_reg <= in_s1_reg;
      req_pipe_reg <= {req_pipe_reg[0], samp};
      last_pipe_reg <= {last_pipe_reg[0], samp_last};
      rx_valid_reg <= req_pipe_reg[1] && last_pipe_reg[1];
      if (req_pipe_reg[1])
      begin
        rxsh_reg <= {rxsh_reg[6:0], in_s2_reg};
        if (last_pipe_reg[1])
        begin
          rx_data_reg <= {rxsh_reg[6:0], in_s2_reg};
        end
      end
    end
  end

  assign link.bclk = bclk_reg;
  assign link.sync = sync_reg;
  assign link.rxd = dout_reg;
  assign rx_data_out = rx_data_reg;
  assign rx_valid_out = rx_valid_reg;
endmodule
`default_nettype wire

// >>> ibp_check_sva.sv
// assertions on the pcm link between highway master and codec end
// assumes the link wires, the 50 MHz clock, its reset and the mode level as inputs
`timescale 1ns/10ps
`default_nettype none
module ibp_check #(
  parameter int FRAME_CYCLES = 800
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic mode_gci_in,
  input wire logic bclk,
  input wire logic sync,
  input wire logic rxd,
  input wire logic txd,
  input wire logic txd_oe_n
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  // ****************************************
  // helper counters
  // ****************************************
  int gap_reg;
  int low_reg;
  logic seen_reg;
  logic sync_d_reg;
  wire logic sync_rise = sync && !sync_d_reg;

  always_ff @(posedge ref_clk_in)
  begin
    sync_d_reg <= sys_rst_in ? 1'b0 : sync;
    seen_reg <= sys_rst_in ? 1'b0 : (seen_reg || sync_rise);
    gap_reg <= (sys_rst_in || sync_rise) ? 1 : gap_reg + 1;
  end

  // cycles the codec has held the line
  always_ff @(posedge ref_clk_in)
  begin
    low_reg <= (sys_rst_in || txd_oe_n) ? 0 : low_reg + 1;
  end

  // ****************************************
  // checks
  // ****************************************
  sync_gap_a: assert property (sync_rise && seen_reg |-> gap_reg == FRAME_CYCLES)
    else $error("frame sync spacing wrong");
  sync_width_a: assert property ($rose(sync) |-> sync [*8] ##1 !sync)
    else $error("frame sync width wrong");
  clk_half_a: assert property ($rose(bclk) |-> bclk [*4] ##1 !bclk)
    else $error("bit clock high phase wrong");
  sync_fall_a: assert property ($fell(bclk) |-> $stable(sync) ##1 $stable(sync))
    else $error("sync moved at clock fall");
  rxd_fall_a: assert property (!mode_gci_in && $fell(bclk) |-> $stable(rxd))
    else $error("receive data moved at clock fall");
  drive_rise_a: assert property ($fell(txd_oe_n) |-> $past(bclk, 1))
    else $error("codec drove line outside high clock phase");
  data_rise_a: assert property ($changed(txd) && !txd_oe_n && !$past(txd_oe_n) |->
    $past(bclk, 1))
    else $error("codec data changed after clock fall");
  release_fall_a: assert property ($rose(txd_oe_n) |-> !$past(bclk, 1))
    else $error("codec released line outside low clock phase");
  drive_len_a: assert property ($rose(txd_oe_n) |-> low_reg == 60 || low_reg == 124)
    else $error("codec drive window length wrong");

  cover property ($rose(txd_oe_n) && low_reg == 60);
  cover property ($rose(txd_oe_n) && low_reg == 124);
  cover property (sync_rise && seen_reg);
endmodule
`default_nettype wire

// >>> test_isdn_bchannel_pcm_port.sv
// self-checking bench: master end and codec end joined by one link
// assumes a shortened frame of 800 clocks; both ends share mode and channel
`timescale 1ns/10ps
`default_nettype none
module test_isdn_bchannel_pcm_port;
  localparam int FRAME_CYC = 800;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic mode_gci = 1'b0;
  logic chan_b2 = 1'b0;
  logic [7:0] cd_data = 8'h00;
  logic cd_valid = 1'b0;
  logic [7:0] ct_data = 8'h00;
  logic ct_valid = 1'b0;
  logic cd_ready;
  logic ct_ready;
  logic [7:0] cd_rx;
  logic [7:0] ct_rx;
  logic cd_rxv;
  logic ct_rxv;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int falls = 0;
  logic [7:0] sh;
  logic bclk_d = 1'b0;
  logic oe_d = 1'b1;
  logic [7:0] cd_q[$];
  logic [7:0] ct_q[$];
  logic [7:0] wire_q[$];

  ibp_if link_if();
  ibp_codec_end #(.FIFO_DEPTH(16)) ibp_codec_end_inst (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .link(link_if), .mode_gci_in(mode_gci), .chan_b2_in(chan_b2),
    .tx_data_in(cd_data), .tx_valid_in(cd_valid), .tx_ready_out(cd_ready),
    .rx_data_out(cd_rx), .rx_valid_out(cd_rxv));
  ibp_ctrl_end #(.FRAME_CYCLES(FRAME_CYC), .HALF_DIV(4)) ibp_ctrl_end_inst (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .link(link_if),
    .mode_gci_in(mode_gci), .chan_b2_in(chan_b2), .tx_data_in(ct_data),
    .tx_valid_in(ct_valid), .tx_ready_out(ct_ready), .rx_data_out(ct_rx),
    .rx_valid_out(ct_rxv));
  ibp_check #(.FRAME_CYCLES(FRAME_CYC)) ibp_check_inst (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .mode_gci_in(mode_gci), .bclk(link_if.bclk),
    .sync(link_if.sync), .rxd(link_if.rxd), .txd(link_if.txd), .txd_oe_n(link_if.txd_oe_n));

  initial forever #10 ref_clk_in = ~ref_clk_in;

  // ****************************************
  // monitors and hang guard
  // ****************************************
  always @(posedge ref_clk_in)
  begin
    cycles++;
    bclk_d <= link_if.bclk;
    oe_d <= link_if.txd_oe_n;
    if (cd_rxv === 1'b1) cd_q.push_back(cd_rx);
    if (ct_rxv === 1'b1) ct_q.push_back(ct_rx);
    // gci holds each bit for two clocks: keep the second fall only
    if (bclk_d && !link_if.bclk && !link_if.txd_oe_n)
    begin
      falls++;
      if (!mode_gci || falls % 2 == 0) sh = {sh[6:0], link_if.txd_line};
    end
    if (link_if.txd_oe_n && !oe_d)
    begin
      wire_q.push_back(sh);
      falls = 0;
    end
    if (cycles > 60000)
    begin
      errors++;
      complete_run();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check_word(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected word at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic check_flag(input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected flag at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic do_reset(input logic gci, input logic b2);
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b1;
    mode_gci <= gci;
    chan_b2 <= b2;
    repeat (6) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    cd_q.delete();
    ct_q.delete();
    wire_q.delete();
  endtask

  task automatic push(input logic to_ctrl, input logic [7:0] w);
    @(posedge ref_clk_in);
    if (to_ctrl) {ct_data, ct_valid} <= {w, 1'b1};
    else {cd_data, cd_valid} <= {w, 1'b1};
    do @(posedge ref_clk_in); while ((to_ctrl ? ct_ready : cd_ready) !== 1'b1);
    if (to_ctrl) ct_valid <= 1'b0;
    else cd_valid <= 1'b0;
  endtask

  task automatic wait_rx(input int n);
    for (int i = 0; i < 2000 * n && (cd_q.size() < n || ct_q.size() < n); i++)
      @(posedge ref_clk_in);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // one word each way, then an empty slot that must carry the idle word
  task automatic swap_words(input logic gci, input logic b2);
    logic [7:0] cw;
    logic [7:0] tw;
    cw = 8'h96 ^ {6'h00, b2, gci};
    tw = 8'h3C ^ {4'h0, b2, gci, 2'h0};
    do_reset(gci, b2);
    // master word first: a gci b1 slot opens at the fourth edge after release
    push(1'b1, tw);
    @(posedge ref_clk_in);
    check_flag(1'b0, ct_ready);
    push(1'b0, cw);
    wait_rx(2);
    check_word(cw, ct_q[0]);
    check_word(tw, cd_q[0]);
    check_word(8'hFF, ct_q[1]);
    check_word(8'hFF, cd_q[1]);
    check_word(cw, wire_q[0]);
  endtask

  // codec queue fills until refused, then drains one word per frame in order
  task automatic fill_fifo();
    int n;
    n = 0;
    do_reset(1'b0, 1'b0);
    @(posedge ref_clk_in);
    cd_data <= 8'h40;
    cd_valid <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk_in);
      if (cd_ready === 1'b1)
      begin
        n++;
        cd_data <= 8'h40 + n[7:0];
      end
    end
    check_flag(1'b0, cd_ready);
    // sixteen held plus the one taken by the first slot
    check_flag(1'b1, n == 17);
    cd_valid <= 1'b0;
    wait_rx(n + 1);
    for (int k = 0; k < n; k++)
      check_word(8'h40 + k[7:0], ct_q[k]);
    check_word(8'hFF, ct_q[n]);
  endtask

  task automatic complete_run();
    $display("errors=%0d num_checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    for (int m = 0; m < 4; m++)
      swap_words(m[1], m[0]);
    fill_fifo();
    complete_run();
  end
endmodule
`default_nettype wire
